// ---- design/fault_test_load_and_linkage.sv ----
// linkage word application, scan test sequencing and alternate loader
`timescale 1ns/100ps
module fault_test_load_and_linkage
	import fault_test_pkg::*;
#(
	parameter int CYCLE_W = 8          // width of clock advance count
)
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// microorders from the control store word
	input  wire logic              scanControlOrder,
	input  wire logic [3:0]        emitField,
	input  wire logic              scanToCsaOrder,
	input  wire logic              ioModeOrder,
	input  wire logic              exitInstr,
	input  wire logic [DATA_W-1:0] exitLinkWord,
	input  wire logic              fetchNextLink,
	// fault test sequence
	input  wire logic              testStart,
	input  wire logic [CYCLE_W-1:0] testCycles,
	input  wire logic [DATA_W-1:0] patternWord,
	input  wire logic [DATA_W-1:0] stateWord,
	input  wire logic [DATA_W-1:0] maskWord,
	input  wire logic [DATA_W-1:0] expectedWord,
	// loader start and channel side
	input  wire logic              loadStart,
	input  wire logic              useSeek,
	input  wire logic              chanReq,
	input  wire logic [DATA_W-1:0] chanBufWord,
	input  wire logic [PAR_W-1:0]  chanBufPar,
	input  wire logic              chanEnd,
	// main storage
	input  wire logic [WORD_W-1:0] storeRdata,
	output logic                   storeSelect,
	output logic                   storeWrite,
	output logic [ADDR_W-1:0]      storeAddr,
	output logic [WORD_W-1:0]      storeWdata,
	// channel control
	output logic                   chanStart,
	output logic                   chanSeekCmd,
	output logic                   chanClock,
	// processor state seen by the rest of the machine
	output logic [DATA_W-1:0]      storage_data_reg_q,
	output logic [ADDR_W-1:0]      instruction_address_reg_q,
	output logic [CSA_W-1:0]       control_store_address_reg_q,
	output logic [2:0]             seqCounter_q,
	output logic [3:0]             seqStats_q,
	output logic                   storage_enable_stat_q,
	output logic                   progressive_scan_stat_q,
	output logic                   supervisory_stat_q,
	output logic                   io_mode_stat_q,
	output logic                   seqCounterMode_q,
	output logic                   mainStoreMode_q,
	output logic                   maintMode_q,
	output logic                   loadCheck_q,
	output logic                   loadStalled,
	output logic                   scanInEnable,
	output logic                   clockAdvance,
	output logic                   testDone_q,
	output logic                   testPass
);
	// refused at elaboration: the countdown compare needs at least one bit
	if (CYCLE_W < 1 || CYCLE_W > 16) begin
		$error("CYCLE_W out of range");
	end

	load_state_t ld_q;                 // loader state
	test_state_t ts_q;                 // test sequencer state
	logic [CYCLE_W-1:0] cyc_q;         // clock advance countdown
	logic [PAR_W-1:0] genPar;          // parity made by the processor
	logic parOk;                       // channel parity agrees with ours
	logic maskOk;                      // first test result
	logic lwEnter;                     // linkage word applied this cycle
	logic [DATA_W-1:0] sdrNext;        // next storage data value
	logic stalled;                     // channel ended mid pair

	parity_gen u_par (
		.data (chanBufWord),
		.par  (genPar)
	);

	fault_test_check u_chk (
		.clk      (clk),
		.rst      (rst),
		.response (storage_data_reg_q),
		.maskWord (maskWord),
		.expected (expectedWord),
		.doMask   (ts_q == T_MASK),
		.doExpect (ts_q == T_EXP),
		.maskOk   (maskOk),
		.pass     (testPass)
	);

	// channel parity compared against ours as the second check
	assign parOk = (genPar == chanBufPar);
	// an end of data after only the first word of a pair hangs up
	assign stalled = (ld_q == L_WAIT2) && chanEnd;
	assign lwEnter = exitInstr | fetchNextLink;

	// storage data register source selection
	always_comb begin
		sdrNext = storage_data_reg_q;
		if (exitInstr) begin
			sdrNext = exitLinkWord;
		end else if (fetchNextLink) begin
			sdrNext = storeRdata[WORD_W-1 -: DATA_W];
		end else if (ld_q == L_WAIT1 && chanReq) begin
			sdrNext = chanBufWord;
		end else if (ld_q == L_RD2) begin
			// first word from storage or'ed with the held second word
			sdrNext = storeRdata[WORD_W-1 -: DATA_W] | storage_data_reg_q;
		end else if (ld_q == L_WAIT2 && chanReq) begin
			sdrNext = chanBufWord;
		end else if (ts_q == T_WR) begin
			sdrNext = stateWord;
		end else if (ts_q == T_RD) begin
			sdrNext = storeRdata[WORD_W-1 -: DATA_W];
		end else if (ts_q == T_SCAN) begin
			sdrNext = patternWord;
		end
	end

	// storage data register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			storage_data_reg_q <= '0;
		end else begin
			storage_data_reg_q <= sdrNext;
		end
	end

	// parity held for the stored word, or'ed over the pair
	logic [PAR_W-1:0] parAcc_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			parAcc_q <= '0;
		end else if (ld_q == L_WAIT1 && chanReq) begin
			parAcc_q <= genPar;
		end else if (ld_q == L_WAIT2 && chanReq) begin
			parAcc_q <= parAcc_q | genPar;
		end else if (ld_q == L_RD2) begin
			parAcc_q <= parAcc_q | storeRdata[PAR_W-1:0];
		end
	end

	// control store address only from the dedicated scan path order
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			control_store_address_reg_q <= '0;
		end else if (scanToCsaOrder) begin
			control_store_address_reg_q <=
				storage_data_reg_q[msb(LW_CSA_LO) -: CSA_W];
		end
	end

	// counter and three stats set together by the qualified scan order
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			storage_enable_stat_q   <= 1'b0;
			progressive_scan_stat_q <= 1'b0;
			supervisory_stat_q      <= 1'b0;
		end else if (scanControlOrder && emitField == EMIT_SCAN_SET) begin
			storage_enable_stat_q   <= storage_data_reg_q[msb(LW_SES_BIT)];
			progressive_scan_stat_q <= storage_data_reg_q[msb(LW_PSS_BIT)];
			supervisory_stat_q      <= storage_data_reg_q[msb(LW_SUP_BIT)];
		end
	end

	// io mode stat has an order of its own
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			io_mode_stat_q <= 1'b0;
		end else if (ioModeOrder) begin
			io_mode_stat_q <= storage_data_reg_q[msb(LW_IOM_BIT)];
		end
	end

	// maintenance mode: entered by exit, left on the fetch entry address
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			maintMode_q <= 1'b0;
		end else if (exitInstr) begin
			maintMode_q <= 1'b1;
		end else if (scanToCsaOrder && storage_data_reg_q[msb(LW_CSA_LO) -:
				CSA_W] == IFETCH_ENTRY) begin
			maintMode_q <= 1'b0;
		end
	end

	// loader sequence; stalled state is absorbing until reset or restart
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ld_q <= L_IDLE;
		end else if (loadStart) begin
			ld_q <= L_WAIT1;
		end else begin
			case (ld_q)
			L_WAIT1: begin
				if (chanEnd) begin
					ld_q <= L_DONE;
				end else if (chanReq) begin
					ld_q <= L_WR1;
				end
			end
			L_WR1:   ld_q <= L_WAIT2;
			L_WAIT2: begin
				if (chanReq && !chanEnd) begin
					ld_q <= L_RD2;
				end
			end
			L_RD2:   ld_q <= L_WR2;
			L_WR2:   ld_q <= L_WAIT1;
			default: ld_q <= ld_q;
			endcase
		end
	end

	// sequence counter and stats mirror the loader; frozen on a stall unless the qualified scan order loads the counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seqCounter_q <= '0;
			seqStats_q   <= '0;
		end else if (scanControlOrder && emitField == EMIT_SCAN_SET) begin
			seqCounter_q <= storage_data_reg_q[msb(LW_SEQ_LO) -: 3];
		end else if (stalled) begin
			seqCounter_q <= seqCounter_q;
		end else if (ld_q != L_IDLE && ld_q != L_DONE) begin
			seqCounter_q <= seqCounter_q + 3'h1;
			seqStats_q   <= {ld_q == L_WAIT1, ld_q == L_WR1,
				ld_q == L_RD2, ld_q == L_WR2};
		end
	end

	// mode triggers and parity check indicator
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seqCounterMode_q <= 1'b0;
			mainStoreMode_q  <= 1'b0;
			loadCheck_q      <= 1'b0;
		end else if (loadStart) begin
			seqCounterMode_q <= 1'b1;
			mainStoreMode_q  <= 1'b0;
			loadCheck_q      <= 1'b0;
		end else begin
			if ((ld_q == L_WAIT1 || ld_q == L_WAIT2) && chanReq && !parOk)
				loadCheck_q <= 1'b1;
			if (ld_q == L_WAIT1 && chanEnd) begin
				seqCounterMode_q <= 1'b0;
				mainStoreMode_q  <= 1'b1;
			end
		end
	end

	// instruction address: one step below the load base at load, stepped per pair, linkage stream
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			instruction_address_reg_q <= '0;
		end else if (loadStart) begin
			// first increment lands the first pair at location zero
			instruction_address_reg_q <= LOAD_BASE - WORD_STEP;
		end else if (ld_q == L_WAIT1 && chanReq && !chanEnd) begin
			instruction_address_reg_q <=
				instruction_address_reg_q + WORD_STEP;
		end else if (ld_q == L_WAIT1 && chanEnd) begin
			instruction_address_reg_q <= START_ADDR;
		end else if (lwEnter) begin
			// exit or linkage fetch: step to the next fullword
			instruction_address_reg_q <=
				instruction_address_reg_q + WORD_STEP;
		end
	end

	// test sequencer: scan in, clock advance, store, read, two tests
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ts_q  <= T_IDLE;
			cyc_q <= '0;
		end else begin
			case (ts_q)
			T_IDLE: begin
				if (testStart) begin
					ts_q <= T_SCAN;
				end
			end
			T_SCAN: begin
				cyc_q <= testCycles;
				ts_q  <= (testCycles == '0) ? T_WR : T_CLK;
			end
			T_CLK: begin
				cyc_q <= cyc_q - 1'b1;
				if (cyc_q == {{(CYCLE_W-1){1'b0}}, 1'b1}) begin
					ts_q <= T_WR;
				end
			end
			T_WR:    ts_q <= T_RD;
			T_RD:    ts_q <= T_MASK;
			T_MASK:  ts_q <= T_EXP;
			default: ts_q <= T_IDLE;
			endcase
		end
	end

	// done flag pulses after the expected test
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			testDone_q <= 1'b0;
		end else begin
			testDone_q <= (ts_q == T_EXP);
		end
	end

	// storage port driving
	always_comb begin
		storeSelect = 1'b0;
		storeWrite  = 1'b0;
		storeAddr   = instruction_address_reg_q;
		storeWdata  = {storage_data_reg_q, parAcc_q};
		if (exitInstr) begin
			storeSelect = 1'b1;
			storeWrite  = 1'b1;
			storeAddr   = EXIT_LW_ADDR;
			storeWdata  = {exitLinkWord, {PAR_W{1'b0}}};
		end else if (ld_q == L_WR1 || ld_q == L_WR2) begin
			storeSelect = 1'b1;
			storeWrite  = 1'b1;
		end else if (ld_q == L_RD2 || fetchNextLink || ts_q == T_RD) begin
			storeSelect = 1'b1;
		end else if (ts_q == T_WR) begin
			storeSelect = 1'b1;
			storeWrite  = 1'b1;
			storeWdata  = {stateWord, {PAR_W{1'b0}}};
		end
	end

	// channel simulation and clocking
	assign chanStart    = loadStart;
	assign chanSeekCmd  = loadStart & useSeek;
	assign chanClock    = (ld_q == L_WAIT1 || ld_q == L_WAIT2) && !stalled;
	assign loadStalled  = stalled;
	assign scanInEnable = (ts_q == T_SCAN);
	assign clockAdvance = (ts_q == T_CLK);
endmodule

// ---- design/fault_test_pkg.sv ----
// shared constants for the fault test load and linkage logic
package fault_test_pkg;
	localparam int DATA_W      = 32;
	localparam int PAR_W       = 4;
	localparam int WORD_W      = DATA_W + PAR_W;
	localparam int ADDR_W      = 24;
	localparam int CSA_W       = 12;
	// linkage word field positions
	localparam int LW_SEQ_LO   = 0;
	localparam int LW_SEQ_HI   = 2;
	localparam int LW_SES_BIT  = 4;
	localparam int LW_PSS_BIT  = 5;
	localparam int LW_SUP_BIT  = 6;
	localparam int LW_IOM_BIT  = 7;
	localparam int LW_CSA_LO   = 19;
	localparam int LW_CSA_HI   = 30;
	// emit value qualifying the scan control order
	localparam logic [3:0] EMIT_SCAN_SET = 4'h8;
	// storage address of the exit linkage word
	localparam logic [ADDR_W-1:0] EXIT_LW_ADDR = 24'h000080;
	// control store entry that returns to instruction fetch
	localparam logic [CSA_W-1:0] IFETCH_ENTRY = 12'hfb9;
	localparam logic [ADDR_W-1:0] WORD_STEP  = 24'h000004;
	localparam logic [ADDR_W-1:0] START_ADDR = 24'h000004;
	localparam logic [ADDR_W-1:0] LOAD_BASE  = 24'h000000;
	// bits are numbered from the left, bit 0 is the most significant
	function automatic int msb(input int b);
		return DATA_W - 1 - b;
	endfunction
	// loader states, gray along the pair path
	typedef enum logic [2:0] {
		L_IDLE  = 3'b000,
		L_WAIT1 = 3'b001,
		L_WR1   = 3'b011,
		L_WAIT2 = 3'b010,
		L_RD2   = 3'b110,
		L_WR2   = 3'b111,
		L_DONE  = 3'b101
	} load_state_t;
	// test sequencer states
	typedef enum logic [2:0] {
		T_IDLE = 3'b000,
		T_SCAN = 3'b001,
		T_CLK  = 3'b011,
		T_WR   = 3'b010,
		T_RD   = 3'b110,
		T_MASK = 3'b111,
		T_EXP  = 3'b101
	} test_state_t;
endpackage

// ---- design/parity_gen.sv ----
// byte parity generator, odd parity per byte
`timescale 1ns/100ps
module parity_gen
	import fault_test_pkg::*;
(
	// data in
	input  wire logic [DATA_W-1:0] data,
	// parity out, one bit per byte
	output logic      [PAR_W-1:0]  par
);
	// odd parity so an all-zero byte still carries a one
	always_comb begin
		for (int i = 0; i < PAR_W; i++) begin
			par[PAR_W-1-i] = ~^data[DATA_W-1-8*i -: 8];
		end
	end
endmodule

// ---- design/fault_test_check.sv ----
// scan-out response check: or with mask, then compare expected
`timescale 1ns/100ps
module fault_test_check
	import fault_test_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// response and reference words
	input  wire logic [DATA_W-1:0] response,
	input  wire logic [DATA_W-1:0] maskWord,
	input  wire logic [DATA_W-1:0] expected,
	// steps of the check
	input  wire logic              doMask,
	input  wire logic              doExpect,
	// results
	output logic                   maskOk,
	output logic                   pass
);
	logic [DATA_W-1:0] ored_q;         // masked response held for the second test

	// first test: masked bits forced to one, all ones means no fault seen
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ored_q <= '0;
			maskOk <= 1'b0;
		end else if (doMask) begin
			ored_q <= response | maskWord;
			maskOk <= &(response | maskWord);
		end
	end

	// second test against the expected response, masked positions ignored
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pass <= 1'b0;
		end else if (doExpect) begin
			pass <= (ored_q == (expected | maskWord));
		end
	end
endmodule

// ---- testbench/ftl_properties.sv ----
// concurrent checks on the load and linkage block ports
`timescale 1ns/100ps
module ftl_properties
	import fault_test_pkg::*;
(
	// clock and reset
	input wire logic			clk,
	input wire logic			rst,
	// orders and requests
	input wire logic			scanControlOrder,
	input wire logic [3:0]			emitField,
	input wire logic			scanToCsaOrder,
	input wire logic			ioModeOrder,
	input wire logic			exitInstr,
	input wire logic [DATA_W-1:0]		exitLinkWord,
	input wire logic			fetchNextLink,
	input wire logic			loadStart,
	// storage port
	input wire logic			storeWrite,
	input wire logic [ADDR_W-1:0]		storeAddr,
	input wire logic [WORD_W-1:0]		storeWdata,
	// processor state
	input wire logic [DATA_W-1:0]		storage_data_reg_q,
	input wire logic [ADDR_W-1:0]		instruction_address_reg_q,
	input wire logic [CSA_W-1:0]		control_store_address_reg_q,
	input wire logic [2:0]			seqCounter_q,
	input wire logic [3:0]			seqStats_q,
	input wire logic			storage_enable_stat_q,
	input wire logic			io_mode_stat_q,
	input wire logic			seqCounterMode_q,
	input wire logic			mainStoreMode_q,
	input wire logic			loadStalled
);
	// short views of the long register names
	wire [DATA_W-1:0]	storage_data_reg = storage_data_reg_q;
	wire [ADDR_W-1:0]	instruction_address_reg = instruction_address_reg_q;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	csa_load_a: assert property (
		scanToCsaOrder |=> control_store_address_reg_q == $past(storage_data_reg[12:1]))
		else $error("csa not loaded");
	csa_hold_a: assert property (
		!scanToCsaOrder |=> $stable(control_store_address_reg_q))
		else $error("csa moved");
	stat_set_a: assert property (
		scanControlOrder && emitField == EMIT_SCAN_SET |=> seqCounter_q ==
		$past(storage_data_reg[31:29]) && storage_enable_stat_q == $past(storage_data_reg[27]))
		else $error("stats not set");
	io_mode_a: assert property (
		1'b1 |=> io_mode_stat_q == ($past(ioModeOrder) ? $past(storage_data_reg[24]) :
		$past(io_mode_stat_q))) else $error("io mode stat");
	exit_store_a: assert property (
		exitInstr |-> storeWrite && storeAddr == EXIT_LW_ADDR &&
		storeWdata[WORD_W-1:PAR_W] == exitLinkWord) else $error("exit store");
	link_step_a: assert property (
		fetchNextLink |-> storeAddr == instruction_address_reg ##1 instruction_address_reg == $past(instruction_address_reg) + WORD_STEP)
		else $error("link fetch step");
	load_init_a: assert property (
		loadStart |=> instruction_address_reg == LOAD_BASE - WORD_STEP && seqCounterMode_q)
		else $error("load start");
	stall_hold_a: assert property (
		loadStalled && !loadStart && !scanControlOrder |=>
		$stable(seqCounter_q) && $stable(seqStats_q)) else $error("stall moved");
	write_addr_a: assert property (
		storeWrite && seqCounterMode_q |-> storeAddr == instruction_address_reg)
		else $error("write address");
	load_done_a: assert property (
		$rose(mainStoreMode_q) |-> instruction_address_reg == START_ADDR && !seqCounterMode_q)
		else $error("load done");
endmodule
bind fault_test_load_and_linkage ftl_properties u_props (.*);

// ---- testbench/chan_model.sv ----
// selector channel model feeding words to the loader
`timescale 1ns/100ps
module chan_model
	import fault_test_pkg::*;
(
	// clock and reset
	input wire logic		clk,
	input wire logic		rst,
	// loader side controls
	input wire logic		chanClock,
	input wire logic		chanStart,
	// scenario knobs: idle gaps, wrong parity, word count
	input wire logic		slow,
	input wire logic		badPar,
	input wire logic [3:0]		nWords,
	// channel outputs
	output logic			chanReq,
	output logic			chanEnd,
	output logic [DATA_W-1:0]	chanBufWord,
	output logic [PAR_W-1:0]	chanBufPar
);
	logic [3:0]		sent_q;	// words handed over
	logic [1:0]		gap_q;	// idle clocks before next word
	logic [DATA_W-1:0]	w;	// next word of the record
	logic [PAR_W-1:0]	p;	// its odd byte parity
	always_comb w = (32'h1 << (sent_q * 3)) | (32'h80000000 >> sent_q);
	// channel side check value sent along with each word
	always_comb for (int i = 0; i < PAR_W; i++) p[i] = ~^w[8*i +: 8];
	// one request per word, raised only while the loader clocks us
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{chanReq, chanEnd, sent_q, gap_q} <= '0;
			{chanBufWord, chanBufPar} <= '0;
		end else if (chanStart) begin
			{chanReq, chanEnd, sent_q} <= '0;
			gap_q <= {2{slow}};
		end else if (chanReq) begin
			// released bus shows the inverse, never the stale word
			chanReq <= 1'b0;
			sent_q <= sent_q + 4'h1;
			chanBufWord <= ~chanBufWord;
			chanBufPar <= ~chanBufPar;
		end else if (chanClock && gap_q != 2'h0) begin
			gap_q <= gap_q - 2'h1;
		end else if (chanClock && sent_q == nWords) begin
			chanEnd <= 1'b1;
		end else if (chanClock) begin
			chanReq <= 1'b1;
			chanBufWord <= w;
			chanBufPar <= p ^ {PAR_W{badPar}};
			gap_q <= {2{slow}};
		end
	end
endmodule

// ---- testbench/test_fault_test_load_and_linkage.sv ----
// self-checking bench for the load and linkage block
`timescale 1ns/100ps
module test_fault_test_load_and_linkage;
	import fault_test_pkg::*;
	// compare, count and report a mismatch
	`define CHK(n, e, a) begin cmp_count++; if ((e) !== (a)) begin fails++; \
		$display("Error %s expected %h seen %h", n, e, a); end end
	logic	clk, rst, scanControlOrder, scanToCsaOrder, ioModeOrder;
	logic	exitInstr, fetchNextLink, testStart, loadStart, useSeek;
	logic	chanReq, chanEnd, storeSelect, storeWrite, chanStart;
	logic	chanSeekCmd, chanClock, storage_enable_stat_q;
	logic	supervisory_stat_q, progressive_scan_stat_q, io_mode_stat_q;
	logic	seqCounterMode_q, mainStoreMode_q, maintMode_q, loadCheck_q;
	logic	loadStalled, scanInEnable, clockAdvance, testDone_q, testPass;
	logic	slow, badPar;
	logic [3:0]		emitField, chanBufPar, seqStats_q, nWords;
	logic [2:0]		seqCounter_q;
	logic [6:0]		held;
	logic [7:0]		testCycles;
	logic [CSA_W-1:0]	control_store_address_reg_q;
	logic [ADDR_W-1:0]	storeAddr, instruction_address_reg_q;
	logic [DATA_W-1:0]	exitLinkWord, patternWord, stateWord, maskWord;
	logic [DATA_W-1:0]	expectedWord, chanBufWord, storage_data_reg_q;
	logic [WORD_W-1:0]	storeRdata, storeWdata, e36, mem [0:63];
	int			fails, cmp_count, nAdv, nScan, nWr, nSel;
	fault_test_load_and_linkage #(.CYCLE_W(8)) dut (.*);
	chan_model u_chan (.*);
	// main storage, read combinationally, written at the cycle end
	assign storeRdata = mem[storeAddr[7:2]];
	always @(posedge clk) if (storeWrite) mem[storeAddr[7:2]] <= storeWdata;
	always #5 clk = ~clk;
	// record words, the same pattern the channel sends
	function automatic logic [DATA_W-1:0] wd(input int k);
		return (32'h1 << (k * 3)) | (32'h80000000 >> k);
	endfunction
	function automatic logic [PAR_W-1:0] pg(input logic [DATA_W-1:0] x);
		for (int i = 0; i < PAR_W; i++) pg[i] = ~^x[8*i +: 8];
	endfunction
	// one-cycle microorder pulse, then settle past the taking edge
	task automatic order(input int k);
		@(posedge clk);
		case (k)
			0: scanControlOrder <= 1'b1;
			1: scanToCsaOrder <= 1'b1;
			2: ioModeOrder <= 1'b1;
			3: fetchNextLink <= 1'b1;
			default: exitInstr <= 1'b1;
		endcase
		@(posedge clk);
		{scanControlOrder, scanToCsaOrder, ioModeOrder} <= '0;
		{fetchNextLink, exitInstr} <= '0;
		#1;
	endtask
	task automatic reset_dut;
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
	endtask
	// start a load and wait, bounded, for completion or a stall
	task automatic load(input logic [3:0] nw, input logic sl, bp);
		@(posedge clk);
		{nWords, slow, useSeek, badPar, loadStart} <= {nw, sl, sl, bp, 1'b1};
		#1 `CHK("chanStart", 1'b1, chanStart)
		`CHK("seek", sl, chanSeekCmd)
		@(posedge clk);
		loadStart <= 1'b0;
		#1 `CHK("iar", 24'hfffffc, instruction_address_reg_q)
		for (int i = 0; i < 300 && !mainStoreMode_q && !loadStalled; i++)
			@(posedge clk) #1;
	endtask
	task automatic close_out;
		$display("compares %0d errors %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// cut a hang short; the whole run needs well under a thousand cycles
	initial begin
		#200000;
		fails++;
		close_out;
	end
	initial begin
		{clk, rst, fails, cmp_count} = {1'b0, 1'b1, 32'h0, 32'h0};
		{scanControlOrder, scanToCsaOrder, ioModeOrder, exitInstr} = '0;
		{fetchNextLink, testStart, loadStart, useSeek, slow, badPar} = '0;
		{emitField, nWords, testCycles} = {4'h0, 4'h0, 8'h05};
		{exitLinkWord, patternWord} = {32'hab000b46, 32'h0f0f0f0f};
		{stateWord, maskWord, expectedWord} = {32'h12340000, 32'hffff, 32'h0};
		foreach (mem[i]) mem[i] = '0;
		mem[1] = {32'h00001f72, 4'h0};
		reset_dut;
		// exit at fullword 0 builds the linkage word and parks it at 80
		order(4);
		`CHK("sdr", 32'hab000b46, storage_data_reg_q)
		`CHK("mem80", 32'hab000b46, mem[32][WORD_W-1:PAR_W])
		`CHK("maint", 1'b1, maintMode_q)
		order(0);
		`CHK("seq", 3'h0, seqCounter_q)
		@(posedge clk) emitField <= EMIT_SCAN_SET;
		order(0);
		`CHK("seq", 3'h5, seqCounter_q)
		`CHK("ses", 1'b1, storage_enable_stat_q)
		`CHK("pss", 1'b0, progressive_scan_stat_q)
		`CHK("sup", 1'b1, supervisory_stat_q)
		`CHK("iom", 1'b0, io_mode_stat_q)
		`CHK("csa", 12'h000, control_store_address_reg_q)
		order(2);
		`CHK("iom", 1'b1, io_mode_stat_q)
		order(1);
		`CHK("csa", 12'h5a3, control_store_address_reg_q)
		// next linkage word at 4 carries the fetch entry
		order(3);
		`CHK("sdr", 32'h00001f72, storage_data_reg_q)
		`CHK("iar", 24'h000008, instruction_address_reg_q)
		order(1);
		`CHK("maint", 1'b0, maintMode_q)
		// two pairs through a slow channel
		load(4'h4, 1'b1, 1'b0);
		for (int k = 0; k < 2; k++) begin
			e36 = {wd(2*k) | wd(2*k+1), pg(wd(2*k)) | pg(wd(2*k+1))};
			`CHK("pair", e36, mem[k])
		end
		`CHK("iar", START_ADDR, instruction_address_reg_q)
		`CHK("msm", 1'b1, mainStoreMode_q)
		`CHK("lchk", 1'b0, loadCheck_q)
		// odd word count, channel parity wrong
		reset_dut;
		load(4'h3, 1'b0, 1'b1);
		`CHK("stall", 1'b1, loadStalled)
		`CHK("msm", 1'b0, mainStoreMode_q)
		`CHK("lchk", 1'b1, loadCheck_q)
		`CHK("odd", {wd(2), pg(wd(2))}, mem[1])
		held = {seqCounter_q, seqStats_q};
		repeat (5) @(posedge clk);
		#1 `CHK("held", held, {seqCounter_q, seqStats_q})
		// scan test, once matching the expected word and once not
		reset_dut;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			// the flipped bit lies outside the mask, so the second test sees it
			expectedWord <= 32'h1234ffff ^ (k << 16);
			testStart <= 1'b1;
			@(posedge clk);
			testStart <= 1'b0;
			{nAdv, nScan, nWr, nSel} = '0;
			for (int i = 0; i < 60; i++) begin
				#1 nAdv += clockAdvance;
				nScan += scanInEnable;
				nWr += storeWrite && storeWdata[WORD_W-1:PAR_W] === stateWord;
				nSel += storeSelect;
				if (testDone_q === 1'b1) break;
				@(posedge clk);
			end
			`CHK("scan", 1, nScan)
			`CHK("adv", 5, nAdv)
			`CHK("wr", 1, nWr)
			`CHK("sel", 2, nSel)
			`CHK("pass", k == 0, testPass)
		end
		close_out;
	end
endmodule
